// ---- dv/adc_ctl_checker.sv ----
// Port assertions for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module adc_ctl_checker import adc_ctl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Interrupt and selection
  input wire logic irq_ack_i,
  input wire logic global_irq_en_i,
  input wire logic irq_o,
  input wire logic [3:0] applied_channel_o,
  input wire logic [1:0] applied_reference_o,
  input wire logic converter_on_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = avs_read_i || avs_write_i;
  property p_wait_answer; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer");
  property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_wait_cause; !avs_waitrequest_o |-> $past(req); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer unasked");
  property p_rdata_hold; $changed(avs_readdata_o) |-> $past(avs_read_i); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_irq_gate; irq_o |-> $past(global_irq_en_i); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  property p_irq_fall;
    $fell(irq_o) |-> $past(irq_ack_i, 2) || $past(avs_write_i, 2) || !$past(global_irq_en_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  property p_enable_write;
    $changed(converter_on_o) |->
      $past(avs_write_i && avs_waitrequest_o && avs_address_i == OFS_CONTROL);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable moved");
  property p_applied_on;
    $changed({applied_channel_o, applied_reference_o}) |-> $past(converter_on_o);
  endproperty
  a_applied_on: assert property (p_applied_on) else $error("applied moved");
  c_irq: cover property ($rose(irq_o));
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_apply: cover property ($changed(applied_channel_o));
endmodule
bind adc_select_buffer_sleep_conv adc_ctl_checker adc_ctl_checker_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_ack_i(irq_ack_i),
  .global_irq_en_i(global_irq_en_i), .irq_o(irq_o), .applied_channel_o(applied_channel_o),
  .applied_reference_o(applied_reference_o), .converter_on_o(converter_on_o));
`default_nettype wire

// ---- dv/adc_select_buffer_sleep_conv_tb.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module adc_select_buffer_sleep_conv_tb import adc_ctl_pkg::*; ;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
  logic avs_waitrequest_o, sleep_enter, cpu_halted, other_wake, cpu_wake_o, irq_ack, irq_o;
  logic global_irq_en_i = 1'b0, trigger_i = 1'b0, sleep_req = 1'b0, wake_req = 1'b0;
  logic converter_on_o;
  logic [2:0] mode = 3'h0, sleep_mode;
  logic [10:0] vin_i = 11'h000, vref_i = 11'h400;
  logic [3:0] applied_channel_o;
  logic [1:0] applied_reference_o;
  int fails = 0, tests_run = 0, cyc = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  adc_select_buffer_sleep_conv adc_select_buffer_sleep_conv_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sleep_enter_i(sleep_enter), .sleep_mode_i(sleep_mode), .cpu_halted_i(cpu_halted),
    .other_wake_i(other_wake), .cpu_wake_o(cpu_wake_o), .global_irq_en_i(global_irq_en_i),
    .irq_ack_i(irq_ack), .trigger_i(trigger_i), .irq_o(irq_o), .vin_i(vin_i),
    .vref_i(vref_i), .applied_channel_o(applied_channel_o),
    .applied_reference_o(applied_reference_o), .converter_on_o(converter_on_o));
  cpu_sleep_model cpu_sleep_model_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req), .mode_i(mode),
    .wake_req_i(wake_req), .cpu_wake_i(cpu_wake_o), .irq_i(irq_o),
    .sleep_enter_o(sleep_enter), .sleep_mode_o(sleep_mode), .cpu_halted_o(cpu_halted),
    .other_wake_o(other_wake), .irq_ack_o(irq_ack));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then idles one cycle.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q, e, what);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  task automatic wait_done;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      acc(1'b0, OFS_CONTROL, 8'h00, q);
      n++;
    end while (q[CTL_START] !== 1'b0 && n < 60);
  endtask
  function automatic logic [31:0] applied();
    return {26'h0, applied_channel_o, applied_reference_o};
  endfunction
  task automatic sleep_pulse(input logic [2:0] m);
    mode <= m;
    sleep_req <= 1'b1;
    idle(1);
    sleep_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    int n;
    idle(20);
    rst_i <= 1'b0;
    idle(1);
    rd(OFS_SELECTION, 32'h0000_0000, "sel reset");
    rd(OFS_CONTROL, 32'h0000_0000, "ctl reset");
    wr(4'h2, 8'hFF);
    rd(4'h2, 32'h0000_0000, "unmapped");
    wr(OFS_SELECTION, 8'hFF);
    rd(OFS_SELECTION, 32'h0000_00EF, "sel readback");
    idle(8);
    chk(applied(), 32'h0000_0000, "applied while off");
    wr(OFS_CONTROL, 8'h80);
    idle(8);
    chk(applied(), 32'h0000_003F, "applied copy");
    wr(OFS_SELECTION, 8'h41);
    idle(8);
    chk(applied(), 32'h0000_0005, "applied recopy");
    $display("test buffer done");
    vin_i <= 11'h7FF;
    vref_i <= 11'h100;
    wr(OFS_CONTROL, 8'hC8);
    idle(4);
    wr(OFS_SELECTION, 8'hC2);
    chk(applied(), 32'h0000_0005, "applied locked");
    rd(OFS_SELECTION, 32'h0000_00C2, "buffer read");
    rd(OFS_CONTROL, 32'h0000_00C8, "start held");
    wait_done;
    rd(OFS_CONTROL, 32'h0000_0098, "done flag");
    chk(applied(), 32'h0000_000B, "applied after done");
    rd(OFS_RESULT, 32'h0000_03FF, "over range");
    wr(OFS_CONTROL, 8'h98);
    rd(OFS_CONTROL, 32'h0000_0088, "done cleared");
    vin_i <= 11'h000;
    wr(OFS_CONTROL, 8'hC8);
    rd(OFS_CONTROL, 32'h0000_00C8, "started");
    wait_done;
    rd(OFS_RESULT, 32'h0000_0000, "zero code");
    $display("test conversion done");
    global_irq_en_i <= 1'b1;
    wr(OFS_CONTROL, 8'h98);
    for (int m = 0; m < 2; m++) begin
      sleep_pulse(3'(m));
      if (m == 0) begin
        idle(5);
        wake_req <= 1'b1;
        idle(1);
        wake_req <= 1'b0;
      end
      n = 0;
      while ((m == 0 ? irq_o : cpu_wake_o) !== 1'b1 && n < 200) begin
        idle(1);
        n++;
      end
      chk({31'h0, m == 0 ? irq_o : cpu_wake_o}, 32'h0000_0001, "wake");
      idle(20);
      rd(OFS_SLEEP, 32'(m), "awake");
      rd(OFS_CONTROL, 32'h0000_0088, "no relaunch");
    end
    $display("test sleep done");
    wr(OFS_CONTROL, 8'hA8);
    trigger_i <= 1'b1;
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      idle(1);
      n++;
    end
    trigger_i <= 1'b0;
    chk({31'h0, irq_o}, 32'h0000_0001, "trigger run");
    wr(OFS_SELECTION, 8'h43);
    chk(applied(), 32'h0000_000B, "relaunch keeps old");
    idle(40);
    chk(applied(), 32'h0000_000D, "later uses new");
    wr(OFS_CONTROL, 8'h88);
    wait_done;
    idle(10);
    rd(OFS_CONTROL, 32'h0000_0088, "free run stopped");
    $display("test free run done");
    sleep_pulse(3'h2);
    idle(60);
    chk({31'h0, converter_on_o}, 32'h0000_0001, "still on");
    rd(OFS_CONTROL, 32'h0000_0088, "no launch");
    rd(OFS_SLEEP, 32'h0000_000A, "asleep other");
    $display("test other sleep done");
    give_verdict;
  end
endmodule
`default_nettype wire

// ---- dv/cpu_sleep_model.sv ----
// CPU and sleep controller stand-in facing the converter control block.
`timescale 1ns/100ps
`default_nettype none
module cpu_sleep_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Bench commands
  input wire logic sleep_req_i,
  input wire logic [2:0] mode_i,
  input wire logic wake_req_i,
  // Block side
  input wire logic cpu_wake_i,
  input wire logic irq_i,
  output logic sleep_enter_o,
  output logic [2:0] sleep_mode_o,
  output logic cpu_halted_o,
  output logic other_wake_o,
  output logic irq_ack_o
);
  assign sleep_mode_o = mode_i;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sleep_enter_o <= 1'b0;
      cpu_halted_o <= 1'b0;
      other_wake_o <= 1'b0;
      irq_ack_o <= 1'b0;
    end else begin
      sleep_enter_o <= sleep_req_i;
      if (sleep_req_i) begin
        cpu_halted_o <= 1'b1;
      end else if (cpu_wake_i || wake_req_i) begin
        cpu_halted_o <= 1'b0;
      end
      other_wake_o <= wake_req_i && cpu_halted_o;
      // The vector is only taken once the core runs again.
      irq_ack_o <= irq_i && !irq_ack_o && !cpu_halted_o;
    end
  end
endmodule
`default_nettype wire

// ---- hw/adc_ctl_pkg.sv ----
// Shared constants for the converter control block.
package adc_ctl_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] OFS_SELECTION = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_RESULT = 4'h8;
  localparam logic [3:0] OFS_SLEEP = 4'hC;
  // Selection register fields.
  localparam int SEL_REF_HI = 7;
  localparam int SEL_REF_LO = 6;
  localparam int SEL_LEFT_ADJ = 5;
  localparam int SEL_CH_HI = 3;
  localparam int SEL_CH_LO = 0;
  // Control register fields.
  localparam int CTL_ENABLE = 7;
  localparam int CTL_START = 6;
  localparam int CTL_AUTO = 5;
  localparam int CTL_DONE = 4;
  localparam int CTL_IRQ_EN = 3;
  localparam int CTL_PS_HI = 2;
  localparam int CTL_PS_LO = 0;
  // Sleep register fields.
  localparam int SLP_MODE_HI = 2;
  localparam int SLP_MODE_LO = 0;
  localparam int SLP_AWAKE = 3;
  localparam logic [2:0] SLEEP_IDLE = 3'h0;
  localparam logic [2:0] SLEEP_NOISE_RED = 3'h1;
  localparam logic [7:0] SEL_WRITE_MASK = 8'hEF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [9:0] CODE_FULL_SCALE = 10'h3FF;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  // Conversion lengths in converter clocks.
  localparam logic [4:0] CONV_NORMAL_CYC = 5'h0D;
  localparam logic [4:0] CONV_FIRST_CYC = 5'h19;
  localparam logic [4:0] ONE_CYC = 5'h01;
  localparam logic [6:0] PS_MAX = 7'h7F;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;
endpackage

// ---- hw/adc_prescaler.sv ----
// Converter clock prescaler producing a one-cycle tick.
`timescale 1ns/100ps
`default_nettype none
module adc_prescaler import adc_ctl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic [2:0] select_i,
  // Tick
  output logic tick_o
);
  logic [6:0] count_ff;
  logic [6:0] limit;

  // Division factors 2,2,4,...,128 as terminal counts.
  always_comb begin
    if (select_i == 3'h0) begin
      limit = 7'h01;
    end else begin
      limit = 7'((8'h01 << select_i) - 8'h01);
    end
  end

  // Held in reset while the converter is off.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !enable_i || count_ff >= limit) begin
      count_ff <= 7'h00;
    end else begin
      count_ff <= count_ff + 7'h01;
    end
  end

  assign tick_o = enable_i && (count_ff >= limit);
endmodule
`default_nettype wire

// ---- hw/adc_sar_core.sv ----
// Behavioural successive-approximation result generator.
`timescale 1ns/100ps
`default_nettype none
module adc_sar_core import adc_ctl_pkg::*; (
  // Analog stand-in: input and reference as codes
  input wire logic [10:0] vin_i,
  input wire logic [10:0] vref_i,
  // Result
  output logic [9:0] code_o
);
  logic [21:0] scaled;

  // Scale, round to nearest, and clamp to full scale when the input reaches or exceeds a nonzero reference; a zero reference gives zero.
  always_comb begin
    scaled = {vin_i, 10'h000} + {12'h000, vref_i[10:1]};
    if (vref_i == 11'h000) begin
      code_o = CODE_ZERO;
    end else if (vin_i >= vref_i) begin
      code_o = CODE_FULL_SCALE;
    end else begin
      code_o = 10'(scaled / {11'h000, vref_i});
    end
  end
endmodule
`default_nettype wire

// ---- hw/adc_select_buffer_sleep_conv.sv ----
// Converter control: buffered selection, start logic and noise-canceler sleep.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module adc_select_buffer_sleep_conv import adc_ctl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sleep controller
  input wire logic sleep_enter_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic cpu_halted_i,
  input wire logic other_wake_i,
  output logic cpu_wake_o,
  // Interrupt request and auto trigger
  input wire logic global_irq_en_i,
  input wire logic irq_ack_i,
  input wire logic trigger_i,
  output logic irq_o,
  // Analog stand-in and applied selection
  input wire logic [10:0] vin_i,
  input wire logic [10:0] vref_i,
  output logic [3:0] applied_channel_o,
  output logic [1:0] applied_reference_o,
  output logic converter_on_o
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] selection_register_ff;
  logic [3:0] applied_channel_ff;
  logic [1:0] applied_reference_ff;
  logic converter_enable_ff;
  logic auto_trigger_enable_ff;
  logic conversion_done_flag_ff;
  logic irq_enable_ff;
  logic [2:0] prescale_sel_ff;
  logic start_req_ff;
  logic first_conv_ff;
  logic [4:0] cycle_ff;
  logic [4:0] conv_len_ff;
  logic [9:0] result_ff;
  logic asleep_ff;
  logic sleep_launch_ff;
  logic cpu_wake_ff;
  logic irq_ff;
  logic trig_prev_ff;
  logic [31:0] readdata_ff;
  logic waitrequest_ff;
  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic tick;
  logic [9:0] code;
  logic wr_sel;
  logic wr_ctl;
  logic wr_slp;
  logic finish;
  logic last_cycle;
  logic trig_edge;
  logic noise_ok;
  logic sleep_start;
  logic access;

  function automatic logic is_noise_mode(input logic [2:0] mode);
    is_noise_mode = (mode == SLEEP_IDLE) || (mode == SLEEP_NOISE_RED);
  endfunction

  adc_prescaler adc_prescaler_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(converter_enable_ff),
    .select_i(prescale_sel_ff),
    .tick_o(tick)
  );

  adc_sar_core adc_sar_core_i (
    .vin_i(vin_i),
    .vref_i(vref_i),
    .code_o(code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // One wait cycle per access keeps read data a registered value.
  assign access = (avs_read_i || avs_write_i) && waitrequest_ff;
  assign wr_sel = avs_write_i && waitrequest_ff && (avs_address_i == OFS_SELECTION);
  assign wr_ctl = avs_write_i && waitrequest_ff && (avs_address_i == OFS_CONTROL);
  assign wr_slp = avs_write_i && waitrequest_ff && (avs_address_i == OFS_SLEEP);
  assign last_cycle = (state_ff == ST_CONV) && (cycle_ff == conv_len_ff - ONE_CYC);
  assign finish = last_cycle && tick;
  assign trig_edge = trigger_i && !trig_prev_ff;
  assign noise_ok = converter_enable_ff && !auto_trigger_enable_ff && irq_enable_ff
                    && (state_ff == ST_IDLE) && !start_req_ff;
  assign sleep_start = sleep_launch_ff && cpu_halted_i && noise_ok;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= !access;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read_i && waitrequest_ff) begin
      if (avs_address_i == OFS_SELECTION) begin
        readdata_ff <= {24'h00_0000, selection_register_ff};
      end else if (avs_address_i == OFS_CONTROL) begin
        readdata_ff <= {24'h00_0000, converter_enable_ff, start_req_ff,
                        auto_trigger_enable_ff, conversion_done_flag_ff,
                        irq_enable_ff, prescale_sel_ff};
      end else if (avs_address_i == OFS_RESULT) begin
        if (selection_register_ff[SEL_LEFT_ADJ]) begin
          readdata_ff <= {16'h0000, result_ff, 6'h00};
        end else begin
          readdata_ff <= {22'h00_0000, result_ff};
        end
      end else if (avs_address_i == OFS_SLEEP) begin
        readdata_ff <= {28'h000_0000, asleep_ff, sleep_mode_i};
      end else begin
        readdata_ff <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The buffer is written at any time; reserved bit 4 reads zero.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      selection_register_ff <= BYTE_ZERO;
    end else if (wr_sel) begin
      selection_register_ff <= avs_writedata_i[7:0] & SEL_WRITE_MASK;
    end
  end

  // Applied selection follows the buffer on ticks while the converter is on, outside a conversion and in its last clock.
  // The relaunched free-running conversion therefore uses what was latched before.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      applied_channel_ff <= 4'h0;
      applied_reference_ff <= 2'h0;
    end else if (tick && converter_enable_ff
                 && (state_ff != ST_CONV || last_cycle)) begin
      applied_channel_ff <= selection_register_ff[SEL_CH_HI:SEL_CH_LO];
      applied_reference_ff <= selection_register_ff[SEL_REF_HI:SEL_REF_LO];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      converter_enable_ff <= 1'b0;
      auto_trigger_enable_ff <= 1'b0;
      irq_enable_ff <= 1'b0;
      prescale_sel_ff <= 3'h0;
    end else if (wr_ctl) begin
      converter_enable_ff <= avs_writedata_i[CTL_ENABLE];
      auto_trigger_enable_ff <= avs_writedata_i[CTL_AUTO];
      irq_enable_ff <= avs_writedata_i[CTL_IRQ_EN];
      prescale_sel_ff <= avs_writedata_i[CTL_PS_HI:CTL_PS_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start bit stays high through the conversion; free running keeps it high.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !converter_enable_ff) begin
      start_req_ff <= 1'b0;
    end else if (wr_ctl && avs_writedata_i[CTL_START]) begin
      start_req_ff <= 1'b1;
    end else if (sleep_start || (auto_trigger_enable_ff && trig_edge && state_ff == ST_IDLE)) begin
      start_req_ff <= 1'b1;
    end else if (finish && !auto_trigger_enable_ff) begin
      start_req_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_req_ff || sleep_start) begin
          nxt_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (tick) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (finish) begin
          nxt_state = auto_trigger_enable_ff ? ST_CONV : ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !converter_enable_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // First conversion after enable is the long one.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !converter_enable_ff) begin
      first_conv_ff <= 1'b1;
      cycle_ff <= 5'h00;
      conv_len_ff <= CONV_FIRST_CYC;
    end else if (state_ff == ST_ARMED && tick) begin
      cycle_ff <= 5'h00;
      conv_len_ff <= first_conv_ff ? CONV_FIRST_CYC : CONV_NORMAL_CYC;
      first_conv_ff <= 1'b0;
    end else if (finish) begin
      cycle_ff <= 5'h00;
      conv_len_ff <= CONV_NORMAL_CYC;
    end else if (state_ff == ST_CONV && tick) begin
      cycle_ff <= cycle_ff + ONE_CYC;
    end
  end

  // Result and done flag update in the same step; a new completion beats a clear.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      result_ff <= CODE_ZERO;
    end else if (finish) begin
      result_ff <= code;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      conversion_done_flag_ff <= 1'b0;
    end else if (finish) begin
      conversion_done_flag_ff <= 1'b1;
    end else if ((wr_ctl && avs_writedata_i[CTL_DONE]) || irq_ack_i) begin
      conversion_done_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trigger_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep entry arms a launch only in Idle or Noise Reduction; other modes only set the asleep flag.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      asleep_ff <= 1'b0;
      sleep_launch_ff <= 1'b0;
    end else if (sleep_enter_i) begin
      asleep_ff <= 1'b1;
      sleep_launch_ff <= is_noise_mode(sleep_mode_i);
    end else if (cpu_wake_ff || other_wake_i) begin
      asleep_ff <= 1'b0;
      sleep_launch_ff <= 1'b0;
    end else if (sleep_start) begin
      sleep_launch_ff <= 1'b0;
    end
  end

  // Completion request is raised whether or not the CPU is already awake.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      cpu_wake_ff <= 1'b0;
    end else begin
      irq_ff <= conversion_done_flag_ff && irq_enable_ff && global_irq_en_i;
      cpu_wake_ff <= asleep_ff && conversion_done_flag_ff && irq_enable_ff;
    end
  end

  assign avs_readdata_o = readdata_ff;
  assign avs_waitrequest_o = waitrequest_ff;
  assign cpu_wake_o = cpu_wake_ff;
  assign irq_o = irq_ff;
  assign applied_channel_o = applied_channel_ff;
  assign applied_reference_o = applied_reference_ff;
  assign converter_on_o = converter_enable_ff;
endmodule
`default_nettype wire
